/* File: adcss_assertions.sv */
// checker for the serial port, align/clear and ready timing of adcss_top
`timescale 1ns/100ps
`default_nettype none
module adcss_chk #(parameter POR_CYC = 50000) (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        align_or_clear_n,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        serial_out,
    input wire logic        serial_out_oe,
    input wire logic [23:0] rx_word,
    input wire logic        rx_valid,
    input wire logic        conversion_ready,
    input wire logic        sync_pulse,
    input wire logic        reset_pulse,
    input wire logic        regs_loaded
);
    int   hi;
    int   cyc;
    logic br;
    logic seen;
    // ----------------------------------------
    // helpers: a sync or reset during a high phase shortens it, so it is excused
    // ----------------------------------------
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hi <= 0;
            cyc <= 0;
            br <= 1'b0;
            seen <= 1'b0;
        end else begin
            hi <= conversion_ready ? hi + 1 : 0;
            br <= conversion_ready ? (br | sync_pulse | reset_pulse) : 1'b0;
            cyc <= reset_pulse ? 0 : cyc + 1;
            seen <= reset_pulse ? 1'b0 : (seen | conversion_ready);
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_idle;
        (!cs_n && !sclk)[*8];
    endsequence
    property p_oe_on; $fell(cs_n) |-> ##[2:6] serial_out_oe; endproperty
    property p_oe_off; $rose(cs_n) |-> ##[2:6] !serial_out_oe; endproperty
    property p_so_hold; s_idle |=> $stable(serial_out); endproperty
    property p_rst; reset_pulse |-> !align_or_clear_n ##1 !reset_pulse; endproperty
    property p_sync; sync_pulse |-> align_or_clear_n && !reset_pulse ##1 !sync_pulse; endproperty
    property p_hi; $fell(conversion_ready) && !br |-> hi >= 62 && hi <= 66; endproperty
    property p_acq; $rose(regs_loaded) |-> cyc >= 995 && cyc <= 1005; endproperty
    property p_por; $rose(conversion_ready) && !seen |-> cyc >= POR_CYC && cyc <= POR_CYC + 24; endproperty
    property p_rx; rx_valid |=> !rx_valid && $stable(rx_word); endproperty
    a_oe_on: assert property (p_oe_on) else $error("oe not raised after cs fall");
    a_oe_off: assert property (p_oe_off) else $error("oe not released after cs rise");
    a_so_hold: assert property (p_so_hold) else $error("serial_out moved without sclk rise");
    a_rst: assert property (p_rst) else $error("bad reset pulse");
    a_sync: assert property (p_sync) else $error("bad sync pulse");
    a_hi: assert property (p_hi) else $error("ready high phase wrong length");
    a_acq: assert property (p_acq) else $error("defaults loaded at wrong time");
    a_por: assert property (p_por) else $error("first ready at wrong time");
    a_rx: assert property (p_rx) else $error("rx_valid not a single pulse");
endmodule
bind adcss_top adcss_chk #(.POR_CYC(POR_CYC)) i_adcss_chk (
    .mclk             (mclk),
    .rstn             (rstn),
    .align_or_clear_n (align_or_clear_n),
    .sclk             (sclk),
    .cs_n             (cs_n),
    .serial_out       (serial_out),
    .serial_out_oe    (serial_out_oe),
    .rx_word          (rx_word),
    .rx_valid         (rx_valid),
    .conversion_ready (conversion_ready),
    .sync_pulse       (sync_pulse),
    .reset_pulse      (reset_pulse),
    .regs_loaded      (regs_loaded)
);
`default_nettype wire

/* File: adcss_consts.vh */
// constants for the adc serial port, align/clear pin and ready pulse logic
// Function
// R1: a low level on the align/clear pin lasting 2048 master clock periods or more causes a full reset.
// R2: a low pulse of 1 to 2047 master clock periods is a synchronisation request, not a reset.
// R3: the host keeps the align/clear pin stable ahead of each master clock rising edge, where it is sampled.
// R4: conversion_ready is high for 4 and then low for 4 master clock periods in each pulse; the code keeps it low for the rest of CONV_PERIOD (2044).
// R5: the first conversion_ready rising edge comes about 250 us after power comes up.
// R6: register defaults are loaded within 5 us after reset.
// R7: the serial port uses idle-low clock and phase one: data changes on one edge and is sampled on the other.
// R8: the host changes chip select only while the serial clock is low.
// R9: serial input bits are captured on falling edges of the serial clock.
// R10: serial output moves to the next bit after each rising serial clock edge while chip select is low.
// R11: serial output is driven after chip select falls and released after it rises.
// R12: a partial frame with no completed activity for 32768 master clock periods is dropped.
// R13: the align/clear pin aligns conversions across devices and to external events.
`ifndef ADCSS_CONSTS_VH
`define ADCSS_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define ADCSS_MCLK_MHZ      200
`define ADCSS_POR_US        250
`define ADCSS_POR_CYC       (`ADCSS_POR_US * `ADCSS_MCLK_MHZ)
`define ADCSS_REGACQ_US     5
`define ADCSS_REGACQ_CYC    (`ADCSS_REGACQ_US * `ADCSS_MCLK_MHZ)
`define ADCSS_RESET_MASTER_CLOCK_IN   2048
`define ADCSS_TIMEOUT_MASTER_CLOCK_IN 32768
`define ADCSS_READY_HALF    4
`define ADCSS_CONV_PERIOD   2048

// ----------------------------------------
// frame
// ----------------------------------------
`define ADCSS_WORD_BITS     24
`define ADCSS_RESET_WORD    24'h00_0000

`endif

/* File: adcss_host.sv */
// host model: serial bus master for the adc serial port
`timescale 1ns/100ps
`default_nettype none
module adcss_host (
    output var logic sclk,
    output var logic cs_n,
    output var logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end
    // n bits msb first; a short frame leaves cs low so the device must time it out
    task automatic xfer(input logic [23:0] d, input int n, output logic [23:0] q);
        int i;
        q = 24'h00_0000;
        cs_n = 1'b0;
        #40;
        for (i = 23; i > 23 - n; i--) begin
            sclk = 1'b1;
            serial_in = d[i];
            #40;
            sclk = 1'b0;
            q[i] = (serial_out_oe === 1'b1) ? serial_out : ~serial_out;
            #40;
        end
        if (n == 24) cs_n = 1'b1;
        serial_in = ~serial_in;
        #40;
    endtask
endmodule
`default_nettype wire

/* File: adcss_sync.v */
// two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module adcss_sync #(
    parameter WIDTH = 1
) (
    input  wire             mclk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] pin,
    output reg  [WIDTH-1:0] synced
);
    reg [WIDTH-1:0] stage1;

    // first stage feeds only the second; all logic reads the second
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= {WIDTH{1'b0}};
            synced <= {WIDTH{1'b0}};
        end else begin
            stage1 <= pin;
            synced <= stage1;
        end
    end
endmodule
`default_nettype wire

/* File: adcss_top.v */
// serial port, align/clear decoding and conversion ready generation
`timescale 1ns/100ps
`default_nettype none
`include "adcss_consts.vh"
module adcss_top #(
    parameter WORD_BITS   = `ADCSS_WORD_BITS,
    parameter POR_CYC     = `ADCSS_POR_CYC,
    parameter TIMEOUT_CLK = `ADCSS_TIMEOUT_MASTER_CLOCK_IN,
    parameter CONV_PERIOD = `ADCSS_CONV_PERIOD
) (
    input  wire                 mclk,
    input  wire                 rstn,
    input  wire                 master_clock_in,
    input  wire                 align_or_clear_n,
    input  wire                 sclk,
    input  wire                 cs_n,
    input  wire                 serial_in,
    input  wire [WORD_BITS-1:0] tx_word,
    output reg                  serial_out,
    output reg                  serial_out_oe,
    output reg  [WORD_BITS-1:0] rx_word,
    output reg                  rx_valid,
    output reg                  conversion_ready,
    output reg                  sync_pulse,
    output reg                  reset_pulse,
    output reg                  regs_loaded
);
    // ----------------------------------------
    // compare points, cut to their counter widths on purpose
    // ----------------------------------------
    localparam integer LOW_LAST_I  = `ADCSS_RESET_MASTER_CLOCK_IN - 1;
    localparam integer LOW_LIM_I   = `ADCSS_RESET_MASTER_CLOCK_IN;
    localparam integer ACQ_LAST_I  = `ADCSS_REGACQ_CYC - 1;
    localparam integer POR_LAST_I  = POR_CYC - 1;
    localparam integer HALF_I      = `ADCSS_READY_HALF;
    localparam integer CONV_LAST_I = CONV_PERIOD - 1;
    localparam integer BIT_LAST_I  = WORD_BITS - 1;
    localparam integer IDLE_LAST_I = TIMEOUT_CLK - 1;
    // counters are sized for the documented counts; a larger parameter
    // would wrap here rather than widen them
    localparam [11:0]  LOW_LAST    = LOW_LAST_I[11:0];
    localparam [11:0]  LOW_LIM     = LOW_LIM_I[11:0];
    localparam [15:0]  ACQ_LAST    = ACQ_LAST_I[15:0];
    localparam [15:0]  POR_LAST    = POR_LAST_I[15:0];
    localparam [15:0]  HALF        = HALF_I[15:0];
    localparam [15:0]  CONV_LAST   = CONV_LAST_I[15:0];
    localparam [5:0]   BIT_LAST    = BIT_LAST_I[5:0];
    localparam [16:0]  IDLE_LAST   = IDLE_LAST_I[16:0];

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    wire [4:0] pins_s;
    reg  [2:0] prev;

    adcss_sync #(
        .WIDTH (5)
    ) u_sync (
        .mclk   (mclk),
        .rstn   (rstn),
        // active-low pins enter inverted so the synchroniser's reset value is their idle level
        .pin    ({master_clock_in, ~align_or_clear_n, sclk, ~cs_n, serial_in}),
        .synced (pins_s)
    );

    wire master_clock_in_s  = pins_s[4];
    wire align_low_s = pins_s[3];
    wire sclk_s   = pins_s[2];
    wire sel_s    = pins_s[1];
    wire sdi_s    = pins_s[0];
    wire master_clock_in_up = master_clock_in_s & ~prev[2];
    wire sclk_up  = sclk_s & ~prev[1] & sel_s;
    wire sclk_dn  = ~sclk_s & prev[1] & sel_s;
    wire sel_fall = sel_s & ~prev[0];
    wire sel_rise = ~sel_s & prev[0];

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            prev <= 3'h0;
        end else begin
            prev <= {master_clock_in_s, sclk_s, sel_s};
        end
    end

    // ----------------------------------------
    // align/clear pulse width
    // ----------------------------------------
    // pin is only looked at on master clock rising edges, so the host must
    // hold it steady ahead of them [R3]
    reg  [11:0] low_cnt;
    wire        soft_rst = reset_pulse;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            low_cnt     <= 12'h000;
            sync_pulse  <= 1'b0;
            reset_pulse <= 1'b0;
        end else begin
            sync_pulse  <= 1'b0;
            reset_pulse <= 1'b0;
            if (master_clock_in_up) begin
                if (align_low_s) begin
                    // saturate so a long hold fires the reset only once
                    if (low_cnt != 12'hFFF)
                        low_cnt <= low_cnt + 12'h001;
                    if (low_cnt == LOW_LAST)
                        reset_pulse <= 1'b1; // [R1]
                end else begin
                    low_cnt <= 12'h000;
                    if (low_cnt != 12'h000 && low_cnt < LOW_LIM)
                        sync_pulse <= 1'b1; // [R2] [R13]
                end
            end
        end
    end

    // ----------------------------------------
    // register default load and power-up wait
    // ----------------------------------------
    reg [15:0] acq_cnt;
    reg [15:0] por_cnt;
    reg        running;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            acq_cnt     <= 16'h0000;
            por_cnt     <= 16'h0000;
            regs_loaded <= 1'b0;
            running     <= 1'b0;
        end else if (soft_rst) begin
            acq_cnt     <= 16'h0000;
            por_cnt     <= 16'h0000;
            regs_loaded <= 1'b0;
            running     <= 1'b0;
        end else begin
            if (!regs_loaded) begin
                acq_cnt <= acq_cnt + 16'h0001;
                if (acq_cnt == ACQ_LAST)
                    regs_loaded <= 1'b1; // [R6]
            end
            if (!running) begin
                por_cnt <= por_cnt + 16'h0001;
                if (por_cnt == POR_LAST)
                    running <= 1'b1; // [R5]
            end
        end
    end

    // ----------------------------------------
    // conversion ready pulse
    // ----------------------------------------
    reg [15:0] conv_cnt;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            conv_cnt         <= 16'h0000;
            conversion_ready <= 1'b0;
        end else if (soft_rst || !running) begin
            conv_cnt         <= 16'h0000;
            conversion_ready <= 1'b0;
        end else if (sync_pulse) begin
            // restart the period so that conversions line up with the pin [R13]
            conv_cnt         <= 16'h0000;
            conversion_ready <= 1'b0;
        end else if (master_clock_in_up) begin
            conversion_ready <= (conv_cnt < HALF); // [R4] [R5]
            if (conv_cnt == CONV_LAST)
                conv_cnt <= 16'h0000;
            else
                conv_cnt <= conv_cnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // serial port, idle-low clock, phase one
    // ----------------------------------------
    // relies on the host moving chip select only with sclk low [R8]
    reg [WORD_BITS-1:0] tx_shift;
    reg [WORD_BITS-1:0] rx_shift;
    reg [5:0]           bit_cnt;
    reg [16:0]          idle_cnt;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_shift      <= {WORD_BITS{1'b0}};
            rx_shift      <= {WORD_BITS{1'b0}};
            rx_word       <= `ADCSS_RESET_WORD;
            rx_valid      <= 1'b0;
            bit_cnt       <= 6'h00;
            idle_cnt      <= 17'h0_0000;
            serial_out    <= 1'b0;
            serial_out_oe <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (soft_rst || sel_rise) begin
                serial_out_oe <= 1'b0; // [R11]
                bit_cnt       <= 6'h00;
                idle_cnt      <= 17'h0_0000;
            end else if (sel_fall) begin
                serial_out_oe <= 1'b1; // [R11]
                tx_shift      <= tx_word;
                bit_cnt       <= 6'h00;
                idle_cnt      <= 17'h0_0000;
            end else if (sel_s) begin
                if (sclk_up) begin
                    // output changes on the rising edge [R7] [R10]
                    serial_out <= tx_shift[WORD_BITS-1];
                    tx_shift   <= {tx_shift[WORD_BITS-2:0], 1'b0};
                end
                if (sclk_dn) begin
                    // input is taken on the falling edge [R7] [R9]
                    rx_shift <= {rx_shift[WORD_BITS-2:0], sdi_s};
                    if (bit_cnt == BIT_LAST) begin
                        rx_word  <= {rx_shift[WORD_BITS-2:0], sdi_s};
                        rx_valid <= 1'b1;
                        bit_cnt  <= 6'h00;
                        tx_shift <= tx_word;
                        idle_cnt <= 17'h0_0000;
                    end else begin
                        bit_cnt <= bit_cnt + 6'h01;
                    end
                end else if (master_clock_in_up) begin
                    // a stalled frame is dropped; the next word starts clean [R12]
                    if (idle_cnt == IDLE_LAST) begin
                        idle_cnt <= 17'h0_0000;
                        bit_cnt  <= 6'h00;
                        tx_shift <= tx_word;
                    end else begin
                        idle_cnt <= idle_cnt + 17'h0_0001;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// testbench for adcss_top
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        mclk = 0, rstn = 0, master_clock_in = 0, align_or_clear_n = 1;
    logic [23:0] tx_word = 24'ha5_c396, rx_word, q;
    logic        serial_out, serial_out_oe, rx_valid, conversion_ready, sync_pulse, reset_pulse, regs_loaded;
    wire         sclk, cs_n, serial_in;
    int          err_count = 0, comparisons = 0, cyc, syncs, rsts, t0;
    always #2.5 mclk = ~mclk;
    initial begin
        #3.5;
        forever #40 master_clock_in = ~master_clock_in;
    end
    // cycle count restarts with either reset, so startup times are measured from it
    always @(posedge mclk) begin
        if (!rstn || reset_pulse === 1'b1)
            cyc = 0;
        else
            cyc++;
        if (sync_pulse === 1'b1) syncs++;
        if (reset_pulse === 1'b1) rsts++;
    end
    adcss_top #(
        .POR_CYC     (200),
        .TIMEOUT_CLK (64),
        .CONV_PERIOD (16)
    ) i_adcss_top (
        .mclk             (mclk),
        .rstn             (rstn),
        .master_clock_in  (master_clock_in),
        .align_or_clear_n (align_or_clear_n),
        .sclk             (sclk),
        .cs_n             (cs_n),
        .serial_in        (serial_in),
        .tx_word          (tx_word),
        .serial_out       (serial_out),
        .serial_out_oe    (serial_out_oe),
        .rx_word          (rx_word),
        .rx_valid         (rx_valid),
        .conversion_ready (conversion_ready),
        .sync_pulse       (sync_pulse),
        .reset_pulse      (reset_pulse),
        .regs_loaded      (regs_loaded)
    );
    adcss_host i_adcss_host (
        .sclk          (sclk),
        .cs_n          (cs_n),
        .serial_in     (serial_in),
        .serial_out    (serial_out),
        .serial_out_oe (serial_out_oe)
    );
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wrap_up;
        if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function logic sig(int w);
        case (w)
            0: return regs_loaded;
            1: return conversion_ready;
            default: return !conversion_ready;
        endcase
    endfunction
    // bounded wait; running out ends the run as a failure
    task wait_sig(input int w, input int lim);
        int k;
        k = 0;
        while (sig(w) !== 1'b1) begin
            @(posedge mclk);
            #1;
            k++;
            if (k > lim) begin
                err_count++;
                wrap_up;
            end
        end
    endtask
    // first ready comes well before the defaults are loaded, so it is waited for first
    task t_startup;
        wait_sig(1, 500);
        chk("por_time", 1, cyc >= 200 && cyc <= 224);
        t0 = cyc;
        wait_sig(2, 200);
        chk("ready_high", 1, cyc - t0 >= 62 && cyc - t0 <= 66);
        wait_sig(0, 2000);
        chk("acq_time", 1, cyc >= 995 && cyc <= 1005);
    endtask
    task t_word(input logic [23:0] d);
        i_adcss_host.xfer(d, 24, q);
        chk("dout", tx_word, q);
        chk("din", d, rx_word);
        chk("oe_idle", 0, serial_out_oe);
    endtask
    task t_timeout;
        i_adcss_host.xfer(24'hff_ffff, 5, q);
        repeat (68 * 16) @(posedge mclk);
        #1;
        t_word(24'h12_3456);
    endtask
    // the pin moves on master_clock_in falls so it is settled at every sampling rise
    task t_align(input int n, input int es, input int er);
        syncs = 0;
        rsts = 0;
        @(negedge master_clock_in);
        align_or_clear_n = 1'b0;
        repeat (n) @(negedge master_clock_in);
        align_or_clear_n = 1'b1;
        repeat (8) @(posedge master_clock_in);
        chk("sync_count", es, syncs);
        chk("reset_count", er, rsts);
    endtask
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        rstn = 1'b1;
        t_startup;
        t_word(24'h3c_5a69);
        t_word(24'hc3_a596);
        t_timeout;
        t_align(3, 1, 0);
        t_align(2047, 1, 0);
        t_align(2048, 0, 1);
        chk("regs_cleared", 0, regs_loaded);
        t_startup;
        t_word(24'h5a_0f3c);
        wrap_up;
    end
endmodule
`default_nettype wire
